/* design/axis_interrupt_status_readback.sv */
// Per-axis interrupt factor status, input levels and data readback.
//
// Operation
// - One factor status per axis; reads return the currently selected axis.
// - A factor latches and interrupts only when its enable bit is set.
// - Bit 0 latches on the rising edge of the drive pulse.
// - Bits 1 and 2 latch when counter rises above or falls below lower.
// - Bits 3 and 4 latch when counter falls below or rises above upper.
// - Bits 5 and 6 latch at constant-speed end and start in ramps.
// - Bit 7 latches when the axis finishes driving.
// - Bit 8 latches when automatic home search terminates.
// - Bit 9 latches on synchronous action; bits 15 to 10 read zero.
// - An enabled factor sets its bit and pulls the interrupt low.
// - Reading the factor status clears it and releases the interrupt once no axis has a factor pending.
// - On an 8-bit bus the low byte read performs the clear.
// - Input level registers show raw pin levels, 1 high, 0 low.
// - Upper byte: stops 8-11, external 12-13, in-position 14, alarm 15.
// - A data-read command copies the internal value for host reading.
// - Low data word holds bits 15-0, high word bits 31-16.
// - Read data is plain binary, negatives in two's complement.
`timescale 1ns/100ps
`default_nettype none

module axis_interrupt_status_readback #(
	parameter int unsigned AXES  = 4,
	parameter int unsigned SEL_W = 2
) (
	input  wire logic                                 i_ref_clk,
	input  wire logic                                 i_rst,
	input  wire logic                                 i_axis_sel_wr,
	input  wire logic [SEL_W-1:0]                     i_axis_sel,
	input  wire logic                                 i_enable_wr,
	input  wire logic [axis_irq_pkg::FACTOR_W-1:0]    i_enable_data,
	input  wire logic                                 i_rd_stb,
	input  wire logic [2:0]                           i_rd_addr,
	input  wire logic                                 i_bus8,
	input  wire logic                                 i_rd_high_byte,
	input  wire logic [AXES-1:0]                      i_drive_pulse,
	input  wire logic [AXES-1:0]                      i_above_lower,
	input  wire logic [AXES-1:0]                      i_below_lower,
	input  wire logic [AXES-1:0]                      i_below_upper,
	input  wire logic [AXES-1:0]                      i_above_upper,
	input  wire logic [AXES-1:0]                      i_const_speed,
	input  wire logic [AXES-1:0]                      i_driving,
	input  wire logic [AXES-1:0]                      i_home_busy,
	input  wire logic [AXES-1:0]                      i_sync_act,
	input  wire logic [axis_irq_pkg::BYTE_W-1:0]      i_pins_a,
	input  wire logic [axis_irq_pkg::BYTE_W-1:0]      i_pins_b,
	input  wire logic                                 i_dread_cmd,
	input  wire logic [axis_irq_pkg::DREAD_W-1:0]     i_dread_value,
	output logic      [axis_irq_pkg::WORD_W-1:0]      o_rd_data,
	output logic                                      o_rd_valid,
	output logic                                      o_irq_n
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [axis_irq_pkg::FACTOR_W-1:0] status_q [AXES];
	logic [axis_irq_pkg::FACTOR_W-1:0] enable_q [AXES];
	logic [axis_irq_pkg::FACTOR_W-1:0] event_d  [AXES];
	logic [AXES-1:0]                   pending_d;
	logic [SEL_W-1:0]                  sel_q;
	logic [AXES-1:0]                   pulse_q;
	logic [AXES-1:0]                   ab_lo_q;
	logic [AXES-1:0]                   be_lo_q;
	logic [AXES-1:0]                   be_hi_q;
	logic [AXES-1:0]                   ab_hi_q;
	logic [AXES-1:0]                   cspd_q;
	logic [AXES-1:0]                   drv_q;
	logic [AXES-1:0]                   home_q;
	logic [axis_irq_pkg::BYTE_W-1:0]   pin_a_m_q;
	logic [axis_irq_pkg::BYTE_W-1:0]   pin_a_q;
	logic [axis_irq_pkg::BYTE_W-1:0]   pin_b_m_q;
	logic [axis_irq_pkg::BYTE_W-1:0]   pin_b_q;
	logic [axis_irq_pkg::DREAD_W-1:0]  dread_q;
	logic [axis_irq_pkg::FACTOR_W-1:0] cur_status;
	logic [axis_irq_pkg::WORD_W-1:0]   rd_word;
	logic                              clear_hit;

	// ------------------------------------------------------------------
	// Axis selection, edge history and read clear
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sel_q <= '0;
		end else if (i_axis_sel_wr) begin
			sel_q <= i_axis_sel;
		end
	end

	// Previous levels for edge detection of every axis condition signal except i_sync_act.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pulse_q <= '0;
			ab_lo_q <= '0;
			be_lo_q <= '0;
			be_hi_q <= '0;
			ab_hi_q <= '0;
			cspd_q  <= '0;
			drv_q   <= '0;
			home_q  <= '0;
		end else begin
			pulse_q <= i_drive_pulse;
			ab_lo_q <= i_above_lower;
			be_lo_q <= i_below_lower;
			be_hi_q <= i_below_upper;
			ab_hi_q <= i_above_upper;
			cspd_q  <= i_const_speed;
			drv_q   <= i_driving;
			home_q  <= i_home_busy;
		end
	end

	// The clear is decided by the read strobe, but a new event in the same
	// cycle is ORed in afterwards so it survives the clear.
	assign clear_hit = i_rd_stb && (i_rd_addr == axis_irq_pkg::REG_FACTOR)
		&& (!i_bus8 || !i_rd_high_byte);

	// ------------------------------------------------------------------
	// Per-axis factor latches
	// ------------------------------------------------------------------
	for (genvar a = 0; a < AXES; a++) begin : g_axis
		always_comb begin
			event_d[a] = '0;
			event_d[a][axis_irq_pkg::BIT_PULSE] =
				i_drive_pulse[a] && !pulse_q[a];
			event_d[a][axis_irq_pkg::BIT_GE_LO] =
				i_above_lower[a] && !ab_lo_q[a];
			event_d[a][axis_irq_pkg::BIT_LT_LO] =
				i_below_lower[a] && !be_lo_q[a];
			event_d[a][axis_irq_pkg::BIT_LT_HI] =
				i_below_upper[a] && !be_hi_q[a];
			event_d[a][axis_irq_pkg::BIT_GE_HI] =
				i_above_upper[a] && !ab_hi_q[a];
			event_d[a][axis_irq_pkg::BIT_C_END] =
				!i_const_speed[a] && cspd_q[a];
			event_d[a][axis_irq_pkg::BIT_CONST_SPEED_BEGIN_FLAG] =
				i_const_speed[a] && !cspd_q[a];
			event_d[a][axis_irq_pkg::BIT_D_END] =
				!i_driving[a] && drv_q[a];
			event_d[a][axis_irq_pkg::BIT_HOME_SEARCH_DONE_FLAG] =
				!i_home_busy[a] && home_q[a];
			event_d[a][axis_irq_pkg::BIT_SYNC] = i_sync_act[a];
		end

		always_ff @(posedge i_ref_clk) begin
			if (i_rst) begin
				enable_q[a] <= axis_irq_pkg::ENABLE_RST;
			end else if (i_enable_wr && (sel_q == SEL_W'(a))) begin
				enable_q[a] <= i_enable_data;
			end
		end

		always_ff @(posedge i_ref_clk) begin
			if (i_rst) begin
				status_q[a] <= axis_irq_pkg::FACTOR_RST;
			end else begin
				status_q[a] <= ((clear_hit && (sel_q == SEL_W'(a)))
					? axis_irq_pkg::FACTOR_RST : status_q[a])
					| (event_d[a] & enable_q[a]);
			end
		end

		assign pending_d[a] = |(status_q[a] & enable_q[a]);

		AST_NO_LATCH_DISABLED: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			((status_q[a] & ~$past(status_q[a]) & ~$past(enable_q[a])) == '0))
			else $error("Factor latched while disabled.");
		AST_PULSE_RISE: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			(i_drive_pulse[a] && !pulse_q[a] && enable_q[a][0])
			|=> status_q[a][axis_irq_pkg::BIT_PULSE])
			else $error("Drive pulse rise not latched.");
		AST_LOWER_CMP: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			$rose(i_below_lower[a]) && enable_q[a][axis_irq_pkg::BIT_LT_LO]
			|-> ##1 status_q[a][axis_irq_pkg::BIT_LT_LO])
			else $error("Below lower compare not latched.");
		AST_UPPER_CMP: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			$rose(i_above_upper[a]) && enable_q[a][axis_irq_pkg::BIT_GE_HI]
			|-> ##1 status_q[a][axis_irq_pkg::BIT_GE_HI])
			else $error("Above upper compare not latched.");
		AST_CONST_END: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			$fell(i_const_speed[a]) && enable_q[a][axis_irq_pkg::BIT_C_END]
			|-> ##1 status_q[a][axis_irq_pkg::BIT_C_END])
			else $error("Constant-speed end not latched.");
		AST_DRIVE_END: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			$fell(i_driving[a]) && enable_q[a][axis_irq_pkg::BIT_D_END]
			|-> ##1 status_q[a][axis_irq_pkg::BIT_D_END])
			else $error("Drive end not latched.");
		AST_HOME_END: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			$fell(i_home_busy[a]) && enable_q[a][axis_irq_pkg::BIT_HOME_SEARCH_DONE_FLAG]
			|-> ##1 status_q[a][axis_irq_pkg::BIT_HOME_SEARCH_DONE_FLAG])
			else $error("Home search end not latched.");
		AST_SYNC_ACT: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			i_sync_act[a] && enable_q[a][axis_irq_pkg::BIT_SYNC]
			|=> status_q[a][axis_irq_pkg::BIT_SYNC])
			else $error("Synchronous action not latched.");
		AST_IRQ_LOW: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			(|(event_d[a] & enable_q[a])) |-> ##2 !o_irq_n)
			else $error("Enabled factor did not assert interrupt.");
		AST_CLEAR: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			clear_hit && (sel_q == SEL_W'(a))
			&& ((event_d[a] & enable_q[a]) == '0)
			|=> (status_q[a] == axis_irq_pkg::FACTOR_RST))
			else $error("Status read did not clear.");
		AST_HIGH_BYTE_KEEP: assert property (@(posedge i_ref_clk)
			disable iff (i_rst)
			i_rd_stb && i_bus8 && i_rd_high_byte
			|=> ((status_q[a] | ~$past(status_q[a])) == '1))
			else $error("High byte read disturbed status.");
	end

	// ------------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------------
	// Registered from status so the pin never glitches on a read.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= ~(|pending_d);
		end
	end

	AST_IRQ_HIGH: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		(pending_d == '0) |=> o_irq_n)
		else $error("Interrupt low with nothing pending.");
	AST_IRQ_HOLD: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		(pending_d != '0) |=> !o_irq_n)
		else $error("Interrupt released while factor pending.");

	// ------------------------------------------------------------------
	// Input levels and data readback
	// ------------------------------------------------------------------
	// Pins are asynchronous; two stages, no latching of the level.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			pin_a_m_q <= axis_irq_pkg::PINS_RST;
			pin_a_q   <= axis_irq_pkg::PINS_RST;
			pin_b_m_q <= axis_irq_pkg::PINS_RST;
			pin_b_q   <= axis_irq_pkg::PINS_RST;
		end else begin
			pin_a_m_q <= i_pins_a;
			pin_a_q   <= pin_a_m_q;
			pin_b_m_q <= i_pins_b;
			pin_b_q   <= pin_b_m_q;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			dread_q <= axis_irq_pkg::DREAD_RST;
		end else if (i_dread_cmd) begin
			dread_q <= i_dread_value;
		end
	end

	assign cur_status = status_q[sel_q];

	always_comb begin
		rd_word = axis_irq_pkg::WORD_RST;
		unique case (i_rd_addr)
			axis_irq_pkg::REG_FACTOR:   rd_word = {6'h00, cur_status};
			axis_irq_pkg::REG_INPUT_A:  rd_word = {pin_a_q, 8'h00};
			axis_irq_pkg::REG_INPUT_B:  rd_word = {pin_b_q, 8'h00};
			axis_irq_pkg::REG_DREAD_LO: rd_word = dread_q[15:0];
			axis_irq_pkg::REG_DREAD_HI: rd_word = dread_q[31:16];
			default:                    rd_word = axis_irq_pkg::WORD_RST;
		endcase
	end

	// In 8-bit mode the chosen byte arrives on the low lane.
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rd_data  <= axis_irq_pkg::WORD_RST;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_stb;
			if (i_rd_stb) begin
				o_rd_data <= !i_bus8 ? rd_word
					: {8'h00, i_rd_high_byte ? rd_word[15:8] : rd_word[7:0]};
			end
		end
	end

	AST_SEL_HOLD: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		!i_axis_sel_wr |=> sel_q == $past(sel_q))
		else $error("Axis selection changed without command.");
	AST_READ_SEL: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		i_rd_stb && !i_bus8 && (i_rd_addr == axis_irq_pkg::REG_FACTOR)
		|=> o_rd_valid && (o_rd_data == {6'h00, $past(cur_status)}))
		else $error("Status read returned wrong axis.");
	AST_PIN_LEVEL: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		i_rd_stb && !i_bus8 && (i_rd_addr == axis_irq_pkg::REG_INPUT_B)
		|=> o_rd_data == {$past(pin_b_q), 8'h00})
		else $error("Input level readback mismatch.");
	AST_PIN_PATH: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		##2 pin_a_q == $past(i_pins_a, 2))
		else $error("Pin level not passed through.");
	AST_DREAD_HI: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		i_dread_cmd ##1 (i_rd_stb && !i_bus8 && !i_dread_cmd
		&& (i_rd_addr == axis_irq_pkg::REG_DREAD_HI))
		|=> o_rd_data == $past(i_dread_value, 2) >> 16)
		else $error("High data word mismatch.");
	AST_DREAD_COPY: assert property (@(posedge i_ref_clk)
		disable iff (i_rst)
		i_dread_cmd |=> dread_q == $past(i_dread_value))
		else $error("Data-read value not captured.");

	COV_IRQ_CLEAR: cover property (@(posedge i_ref_clk)
		disable iff (i_rst) !o_irq_n ##1 clear_hit ##2 o_irq_n);
	COV_BYTE_READ: cover property (@(posedge i_ref_clk)
		disable iff (i_rst) i_rd_stb && i_bus8 && !i_rd_high_byte
		&& (i_rd_addr == axis_irq_pkg::REG_FACTOR));
	COV_DREAD: cover property (@(posedge i_ref_clk)
		disable iff (i_rst) i_dread_cmd ##1 i_rd_stb);

endmodule : axis_interrupt_status_readback

`default_nettype wire

/* design/axis_irq_pkg.sv */
// Constants shared by the per-axis interrupt status and readback block.
package axis_irq_pkg;

	// ------------------------------------------------------------------
	// Register indices on the parallel host bus
	// ------------------------------------------------------------------
	localparam logic [2:0] REG_FACTOR   = 3'h3;
	localparam logic [2:0] REG_INPUT_A  = 3'h4;
	localparam logic [2:0] REG_INPUT_B  = 3'h5;
	localparam logic [2:0] REG_DREAD_LO = 3'h6;
	localparam logic [2:0] REG_DREAD_HI = 3'h7;

	// ------------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------------
	localparam int unsigned FACTOR_W  = 10;
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned DREAD_W   = 32;
	localparam int unsigned BIT_PULSE = 0;
	localparam int unsigned BIT_GE_LO = 1;
	localparam int unsigned BIT_LT_LO = 2;
	localparam int unsigned BIT_LT_HI = 3;
	localparam int unsigned BIT_GE_HI = 4;
	localparam int unsigned BIT_C_END = 5;
	localparam int unsigned BIT_CONST_SPEED_BEGIN_FLAG = 6;
	localparam int unsigned BIT_D_END = 7;
	localparam int unsigned BIT_HOME_SEARCH_DONE_FLAG = 8;
	localparam int unsigned BIT_SYNC  = 9;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [FACTOR_W-1:0] FACTOR_RST = 10'h000;
	localparam logic [FACTOR_W-1:0] ENABLE_RST = 10'h000;
	localparam logic [DREAD_W-1:0]  DREAD_RST  = 32'h0000_0000;
	localparam logic [BYTE_W-1:0]   PINS_RST   = 8'h00;
	localparam logic [WORD_W-1:0]   WORD_RST   = 16'h0000;

endpackage : axis_irq_pkg

/* verif/host_bus_model.sv */
// Host processor model driving the parallel register bus.
`timescale 1ns/100ps
`default_nettype none

module host_bus_model (
	input  wire logic        i_ref_clk,
	input  wire logic [15:0] i_rd_data,
	input  wire logic        i_rd_valid,
	output logic             o_sel_wr,
	output logic [1:0]       o_sel,
	output logic             o_en_wr,
	output logic [9:0]       o_en_data,
	output logic             o_rd_stb,
	output logic [2:0]       o_rd_addr,
	output logic             o_bus8,
	output logic             o_hi_byte
);
	initial begin
		{o_sel_wr, o_sel, o_en_wr, o_en_data} = '0;
		{o_rd_stb, o_rd_addr, o_bus8, o_hi_byte} = '0;
	end

	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// Released fields except o_bus8 show the inverse value so stale data is never reused.
	task automatic select(input logic [1:0] axis);
		@(posedge i_ref_clk) #1;
		o_sel = axis;
		o_sel_wr = 1'b1;
		@(posedge i_ref_clk) #1;
		o_sel_wr = 1'b0;
		o_sel = ~axis;
	endtask : select

	task automatic enable(input logic [9:0] mask);
		@(posedge i_ref_clk) #1;
		o_en_data = mask;
		o_en_wr = 1'b1;
		@(posedge i_ref_clk) #1;
		o_en_wr = 1'b0;
		o_en_data = ~mask;
	endtask : enable

	task automatic read(input logic [2:0] addr, input logic b8, hi,
		output logic [15:0] data, output logic ok);
		int n;
		@(posedge i_ref_clk) #1;
		o_rd_addr = addr;
		o_bus8 = b8;
		o_hi_byte = hi;
		o_rd_stb = 1'b1;
		@(posedge i_ref_clk) #1;
		o_rd_stb = 1'b0;
		o_rd_addr = ~addr;
		o_hi_byte = ~hi;
		ok = 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			if (i_rd_valid === 1'b1)
				ok = 1'b1;
			else
				@(posedge i_ref_clk) #1;
		end
		data = i_rd_data;
	endtask : read
endmodule : host_bus_model

`default_nettype wire

/* verif/axis_interrupt_status_readback_test.sv */
// Self-checking testbench for the axis interrupt status block.
`timescale 1ns/100ps
`default_nettype none

module axis_interrupt_status_readback_test;
	logic        ref_clk;
	logic        rst;
	logic        sel_wr, en_wr, rd_stb, bus8, hi_byte;
	logic [1:0]  sel;
	logic [9:0]  en_data;
	logic [2:0]  rd_addr;
	logic [3:0]  ev [9];
	logic [7:0]  pins_a, pins_b;
	logic        dread_cmd;
	logic [31:0] dread_value;
	logic [15:0] rd_data;
	logic        rd_valid, irq_n;
	int          n_errors, checks, b;

	axis_interrupt_status_readback u_axis_interrupt_status_readback (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_axis_sel_wr(sel_wr),
		.i_axis_sel(sel), .i_enable_wr(en_wr), .i_enable_data(en_data),
		.i_rd_stb(rd_stb), .i_rd_addr(rd_addr), .i_bus8(bus8),
		.i_rd_high_byte(hi_byte), .i_drive_pulse(ev[0]),
		.i_above_lower(ev[1]), .i_below_lower(ev[2]),
		.i_below_upper(ev[3]), .i_above_upper(ev[4]),
		.i_const_speed(ev[5]), .i_driving(ev[6]), .i_home_busy(ev[7]),
		.i_sync_act(ev[8]), .i_pins_a(pins_a), .i_pins_b(pins_b),
		.i_dread_cmd(dread_cmd), .i_dread_value(dread_value),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_irq_n(irq_n));

	host_bus_model u_host_bus_model (
		.i_ref_clk(ref_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
		.o_sel_wr(sel_wr), .o_sel(sel), .o_en_wr(en_wr),
		.o_en_data(en_data), .o_rd_stb(rd_stb), .o_rd_addr(rd_addr),
		.o_bus8(bus8), .o_hi_byte(hi_byte));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic stop_test();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [2:0] a, input logic b8, hi,
		input logic [15:0] exp, input string nm);
		logic [15:0] d;
		logic        ok;
		u_host_bus_model.read(a, b8, hi, d, ok);
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH %s read timed out", nm);
			stop_test();
		end else begin
			check(nm, d, exp);
		end
	endtask : rd

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_n

	// Factor bits 6 and up share inputs one place lower; a one-cycle high
	// pulse makes both a rise and a fall, and only the enabled one counts.
	task automatic fire(input int ax, input int bit_n);
		int s;
		s = (bit_n <= 5) ? bit_n : bit_n - 1;
		@(posedge ref_clk) #1;
		ev[s][ax] = 1'b1;
		@(posedge ref_clk) #1;
		ev[s][ax] = 1'b0;
	endtask : fire

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		foreach (ev[i])
			ev[i] = 4'h0;
		{pins_a, pins_b, dread_cmd, dread_value} = '0;
		repeat (10) @(posedge ref_clk);
		#1 rst = 1'b0;
		rd(3'h3, 1'b0, 1'b0, 16'h0000, "factor reset");
		check("irq reset", {15'h0000, irq_n}, 16'h0001);
		for (b = 0; b < 10; b++) begin
			u_host_bus_model.enable(10'h001 << b);
			fire(0, b);
			wait_n(3);
			check("irq set", {15'h0000, irq_n}, 16'h0000);
			rd(3'h3, 1'b0, 1'b0, 16'h0001 << b, "factor");
			wait_n(2);
			check("irq clr", {15'h0000, irq_n}, 16'h0001);
			rd(3'h3, 1'b0, 1'b0, 16'h0000, "factor cleared");
		end
		u_host_bus_model.enable(10'h3fe);
		fire(0, 0);
		wait_n(3);
		rd(3'h3, 1'b0, 1'b0, 16'h0000, "disabled factor");
		check("irq disabled", {15'h0000, irq_n}, 16'h0001);
		u_host_bus_model.select(2'h1);
		u_host_bus_model.enable(10'h080);
		fire(1, 7);
		u_host_bus_model.select(2'h0);
		fire(0, 9);
		wait_n(3);
		rd(3'h3, 1'b0, 1'b0, 16'h0200, "axis0 factor");
		wait_n(2);
		check("irq other axis", {15'h0000, irq_n}, 16'h0000);
		u_host_bus_model.select(2'h1);
		rd(3'h3, 1'b0, 1'b0, 16'h0080, "axis1 factor");
		wait_n(2);
		check("irq all clear", {15'h0000, irq_n}, 16'h0001);
		u_host_bus_model.select(2'h0);
		u_host_bus_model.enable(10'h101);
		fire(0, 0);
		fire(0, 8);
		wait_n(3);
		rd(3'h3, 1'b1, 1'b1, 16'h0001, "factor high byte");
		wait_n(2);
		check("irq after high", {15'h0000, irq_n}, 16'h0000);
		rd(3'h3, 1'b1, 1'b0, 16'h0001, "factor low byte");
		wait_n(2);
		check("irq after low", {15'h0000, irq_n}, 16'h0001);
		rd(3'h3, 1'b0, 1'b0, 16'h0000, "factor after byte");
		u_host_bus_model.select(2'h2);
		u_host_bus_model.enable(10'h3ff);
		u_host_bus_model.select(2'h3);
		u_host_bus_model.enable(10'h3ff);
		for (b = 0; b < 10; b++) begin
			fire(2, b);
			fire(3, b);
		end
		wait_n(3);
		rd(3'h3, 1'b0, 1'b0, 16'h03ff, "axis3 factors");
		wait_n(2);
		check("irq axis2 left", {15'h0000, irq_n}, 16'h0000);
		u_host_bus_model.select(2'h2);
		rd(3'h3, 1'b0, 1'b0, 16'h03ff, "axis2 factors");
		wait_n(2);
		check("irq axes clear", {15'h0000, irq_n}, 16'h0001);
		for (b = 0; b < 2; b++) begin
			pins_a = b ? 8'h3c : 8'ha5;
			pins_b = ~pins_a;
			wait_n(4);
			rd(3'h4, 1'b0, 1'b0, {pins_a, 8'h00}, "input a");
			rd(3'h5, 1'b0, 1'b0, {pins_b, 8'h00}, "input b");
		end
		// The command drops beside the first read, so the high word is read
		// in the very cycle after the capture.
		for (b = 0; b < 2; b++) begin
			@(posedge ref_clk) #1;
			dread_value = b ? 32'h0001_8000 : 32'hffff_fffe;
			dread_cmd = 1'b1;
			fork
				begin
					@(posedge ref_clk) #1;
					dread_cmd = 1'b0;
					dread_value = ~dread_value;
				end
			join_none
			rd(3'h7, 1'b0, 1'b0, b ? 16'h0001 : 16'hffff, "data hi");
			rd(3'h6, 1'b0, 1'b0, b ? 16'h8000 : 16'hfffe, "data lo");
		end
		rd(3'h0, 1'b0, 1'b0, 16'h0000, "unmapped");
		rd(3'h2, 1'b0, 1'b0, 16'h0000, "unmapped");
		stop_test();
	end
endmodule : axis_interrupt_status_readback_test

`default_nettype wire
